// File: core/cwf_chan.v
// Wake detection, timeouts and supply supervision of one CAN transceiver channel
//
// Behaviour
// - Wake-capable monitoring selectable in stop, sleep, restart and normal chip states.
// - Fail-safe chip state forces wake-capable monitoring without software.
// - After valid wake pattern, receive output low until software changes mode.
// - Wake pattern: two dominant phases over filter time, short recessive gap.
// - After bus wake, mode reads the software value (wake-capable outside fail-safe) and receive output stays low.
// - Rearm after software leaves wake-capable mode and selects it again.
// - Rearm automatically on change to stop, sleep or fail-safe state.
// - Rearm never needs the wake status bit cleared.
// - Wake in stop/normal: interrupt low, status set, receive low, state kept.
// - Stop-state wake enables watchdog if disabled and enable-on-wake set.
// - Sleep-state wake requests restart then normal, receive low, source recorded.
// - Leaving sleep through bus wake raises no interrupt.
// - Wake in restart/fail-safe gives restart, no interrupt; supply ramps up in fail-safe (as in sleep), not in restart.
// - Transmit dominant past timeout in normal: driver off, receive-only, fail flag.
// - When transmit dominance ends, driver returns; mode configuration unchanged.
// - Bus dominant past bus timeout sets fail flag in any mode.
// - Normal/receive-only: supply undervoltage sets flag and disables transmitter.
// - Undervoltage end returns to normal automatically; configuration unchanged.
// - After power-up, mode is off, bus pins high impedance, wakes ignored.
// - Receive-only disables driver, keeps reception; allowed in normal and stop.
`timescale 1ns/1ps
`include "cwf_regs.vh"
module cwf_chan #(
   parameter WAKE1_CYC  = `CWF_WAKE1_CYC,  // Least dominant phase in cycles
   parameter WAKE2_CYC  = `CWF_WAKE2_CYC,  // Longest recessive gap in cycles
   parameter TXD_TO_CYC = `CWF_TXD_TO_CYC, // Transmit dominant timeout in cycles
   parameter BUS_TO_CYC = `CWF_BUS_TO_CYC, // Bus dominant timeout in cycles
   parameter CW         = 20               // Counter width
) (
   input  wire       core_clk,               // Core clock, 100 MHz
   input  wire       rst_n,                  // Synchronous reset, active low
   input  wire [1:0] mode_wr_data,           // Software mode value
   input  wire       mode_wr_en,             // Software mode write strobe
   output wire [1:0] mode_rd,                // Mode field as software reads it
   input  wire [2:0] chip_state,             // Current chip state
   input  wire       bus_transmit_in,        // Controller transmit pin, low is dominant
   input  wire       bus_dominant_in,        // Receiver comparator, high is dominant
   input  wire       xcvr_supply_ok_in,      // Supply comparator, high when supply good
   input  wire       dog_enable_on_bus_wake, // Enable watchdog on stop-state bus wake
   input  wire       dog_enabled,            // Watchdog currently enabled
   input  wire       wake_flag_clr,          // Software clear of wake status bit
   input  wire       fail_flag_clr,          // Software clear of failure flag
   input  wire       uv_flag_clr,            // Software clear of undervoltage flag
   output reg        bus_receive_out,        // Receive pin to controller
   output wire       irq_out_n,              // Interrupt, active low
   output reg        chan_bus_wake_flag,     // Wake status bit (both status registers)
   output reg        chan_fail_flag,         // Channel failure flag
   output reg        xcvr_supply_low_flag,   // Supply undervoltage flag
   output reg  [1:0] chip_wake_req,          // Wake request to chip mode control
   output reg        dog_enable_set,         // One-cycle pulse to enable watchdog
   output reg        main_supply_ramp,       // One-cycle pulse to ramp main supply
   output reg        drv_en,                 // Bus driver enable
   output reg        bus_bias_en,            // Bus biasing active (not high impedance)
   output reg        wake_rx_en              // Low-power wake receiver active
);
   // Wake pattern detector states
   localparam [4:0] ST_IDLE  = 5'b00001;
   localparam [4:0] ST_DOM1  = 5'b00010;
   localparam [4:0] ST_REC   = 5'b00100;
   localparam [4:0] ST_DOM2  = 5'b01000;
   localparam [4:0] ST_DONE  = 5'b10000;

   wire [2:0] sync_w;
   wire       txd_s;
   wire       dom_s;
   wire       sup_ok_s;

   reg  [1:0]    mode_ff;
   reg  [4:0]    wst_ff;
   reg  [4:0]    nxt_wst;
   reg  [CW-1:0] wcnt_ff;
   reg  [CW-1:0] nxt_wcnt;
   reg  [CW-1:0] tcnt_ff;
   reg  [CW-1:0] bcnt_ff;
   reg           armed_ff;
   reg           woken_ff;
   reg           txd_to_ff;
   reg           irq_ff;
   reg  [2:0]    chip_prev_ff;
   reg           wake_pulse;

   function [CW-1:0] inc_sat;
      input [CW-1:0] v;
      begin
         inc_sat = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
      end
   endfunction

   cwf_sync #(.WIDTH(3)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in ({~bus_transmit_in, bus_dominant_in, xcvr_supply_ok_in}),
      .sync_out (sync_w)
   );
   assign txd_s    = sync_w[2];
   assign dom_s    = sync_w[1];
   assign sup_ok_s = sync_w[0];

   // Effective mode: fail-safe forces wake-capable
   wire       fsafe     = (chip_state == `CWF_CHIP_FAILSAFE);
   wire [1:0] eff_mode  = fsafe ? `CWF_MODE_WAKE : mode_ff;
   wire       in_wake   = (eff_mode == `CWF_MODE_WAKE);
   wire       in_normal = (eff_mode == `CWF_MODE_NORMAL);
   wire       in_rxonly = (eff_mode == `CWF_MODE_RXONLY);
   wire       low_state = (chip_state == `CWF_CHIP_STOP) || (chip_state == `CWF_CHIP_SLEEP) ||
                          fsafe;
   wire       rearm_chip = low_state && (chip_state != chip_prev_ff);
   wire       mode_leave = mode_wr_en && (mode_wr_data != `CWF_MODE_WAKE);

   assign mode_rd   = mode_ff;
   assign irq_out_n = ~irq_ff;

   // Software mode field; keeps its value through timeouts and undervoltage
   always @(posedge core_clk) begin
      if (!rst_n) begin
         mode_ff <= `CWF_MODE_RESET;
      end else if (mode_wr_en) begin
         mode_ff <= mode_wr_data;
      end
   end

   // Arming: set by leaving wake mode or by entering a low-power chip state
   always @(posedge core_clk) begin
      if (!rst_n) begin
         armed_ff     <= 1'b1;
         chip_prev_ff <= `CWF_CHIP_INIT;
      end else begin
         chip_prev_ff <= chip_state;
         if (mode_leave || rearm_chip) begin
            armed_ff <= 1'b1;
         end else if (wake_pulse) begin
            armed_ff <= 1'b0;
         end
      end
   end

   // Wake pattern detector
   always @* begin
      nxt_wst    = wst_ff;
      nxt_wcnt   = inc_sat(wcnt_ff);
      wake_pulse = 1'b0;
      case (wst_ff)
         ST_IDLE: begin
            nxt_wcnt = {CW{1'b0}};
            if (dom_s) begin
               nxt_wst = ST_DOM1;
            end
         end
         ST_DOM1: begin
            if (!dom_s) begin
               nxt_wst  = ST_IDLE;
               nxt_wcnt = {CW{1'b0}};
            end else if (wcnt_ff >= WAKE1_CYC[CW-1:0]) begin
               nxt_wst  = ST_REC;
               nxt_wcnt = {CW{1'b0}};
            end
         end
         ST_REC: begin
            if (wcnt_ff >= WAKE2_CYC[CW-1:0]) begin
               nxt_wst  = ST_IDLE;
               nxt_wcnt = {CW{1'b0}};
            end else if (dom_s && wcnt_ff != {CW{1'b0}}) begin
               nxt_wst  = ST_DOM2;
               nxt_wcnt = {CW{1'b0}};
            end else if (dom_s) begin
               nxt_wcnt = {CW{1'b0}};
            end
         end
         ST_DOM2: begin
            if (!dom_s) begin
               nxt_wst  = ST_IDLE;
               nxt_wcnt = {CW{1'b0}};
            end else if (wcnt_ff >= WAKE1_CYC[CW-1:0]) begin
               nxt_wst    = ST_DONE;
               nxt_wcnt   = {CW{1'b0}};
               wake_pulse = armed_ff;
            end
         end
         ST_DONE: begin
            nxt_wcnt = {CW{1'b0}};
            if (!dom_s) begin
               nxt_wst = ST_IDLE;
            end
         end
         default: begin
            nxt_wst  = ST_IDLE;
            nxt_wcnt = {CW{1'b0}};
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (!rst_n || !in_wake) begin
         wst_ff  <= ST_IDLE;
         wcnt_ff <= {CW{1'b0}};
      end else begin
         wst_ff  <= nxt_wst;
         wcnt_ff <= nxt_wcnt;
      end
   end

   // Wake result: receive held low, chip actions by chip state
   always @(posedge core_clk) begin
      if (!rst_n) begin
         woken_ff           <= 1'b0;
         chan_bus_wake_flag <= 1'b0;
         irq_ff             <= 1'b0;
         chip_wake_req      <= `CWF_REQ_NONE;
         dog_enable_set     <= 1'b0;
         main_supply_ramp   <= 1'b0;
      end else begin
         chip_wake_req    <= `CWF_REQ_NONE;
         dog_enable_set   <= 1'b0;
         main_supply_ramp <= 1'b0;
         irq_ff           <= 1'b0;
         if (mode_wr_en && mode_wr_data != eff_mode) begin
            woken_ff <= 1'b0;
         end else if (wake_pulse) begin
            woken_ff <= 1'b1;
         end
         if (wake_pulse) begin
            chan_bus_wake_flag <= 1'b1;
         end else if (wake_flag_clr) begin
            chan_bus_wake_flag <= 1'b0;
         end
         if (wake_pulse) begin
            case (chip_state)
               `CWF_CHIP_NORMAL: begin
                  irq_ff <= 1'b1;
               end
               `CWF_CHIP_STOP: begin
                  irq_ff         <= 1'b1;
                  dog_enable_set <= dog_enable_on_bus_wake && !dog_enabled;
               end
               `CWF_CHIP_SLEEP: begin
                  chip_wake_req    <= `CWF_REQ_RESTART;
                  main_supply_ramp <= 1'b1;
               end
               `CWF_CHIP_RESTART: begin
                  chip_wake_req <= `CWF_REQ_RESTART;
               end
               `CWF_CHIP_FAILSAFE: begin
                  chip_wake_req    <= `CWF_REQ_RESTART;
                  main_supply_ramp <= 1'b1;
               end
               default: begin
                  irq_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // Transmit dominant timeout and bus dominant clamping counters
   wire txd_to_hit = (tcnt_ff >= TXD_TO_CYC[CW-1:0]);
   wire bus_to_hit = (bcnt_ff == BUS_TO_CYC[CW-1:0]);

   always @(posedge core_clk) begin
      if (!rst_n) begin
         tcnt_ff   <= {CW{1'b0}};
         bcnt_ff   <= {CW{1'b0}};
         txd_to_ff <= 1'b0;
      end else begin
         if (in_normal && txd_s) begin
            tcnt_ff <= inc_sat(tcnt_ff);
         end else begin
            tcnt_ff <= {CW{1'b0}};
         end
         if (!txd_s) begin
            txd_to_ff <= 1'b0;
         end else if (in_normal && txd_to_hit) begin
            txd_to_ff <= 1'b1;
         end
         if (dom_s) begin
            bcnt_ff <= inc_sat(bcnt_ff);
         end else begin
            bcnt_ff <= {CW{1'b0}};
         end
      end
   end

   // Failure and undervoltage flags; a set wins over a clear
   always @(posedge core_clk) begin
      if (!rst_n) begin
         chan_fail_flag       <= 1'b0;
         xcvr_supply_low_flag <= 1'b0;
      end else begin
         if ((in_normal && txd_s && txd_to_hit) || (dom_s && bus_to_hit)) begin
            chan_fail_flag <= 1'b1;
         end else if (fail_flag_clr) begin
            chan_fail_flag <= 1'b0;
         end
         if ((in_normal || in_rxonly) && !sup_ok_s) begin
            xcvr_supply_low_flag <= 1'b1;
         end else if (uv_flag_clr) begin
            xcvr_supply_low_flag <= 1'b0;
         end
      end
   end

   // Pin and stage control
   always @(posedge core_clk) begin
      if (!rst_n) begin
         bus_receive_out <= 1'b1;
         drv_en          <= 1'b0;
         bus_bias_en     <= 1'b0;
         wake_rx_en      <= 1'b0;
      end else begin
         // Driver only in normal mode, no timeout, supply good
         drv_en <= in_normal && !txd_to_ff && !(txd_s && txd_to_hit) && sup_ok_s;
         bus_bias_en <= in_normal || in_rxonly;
         wake_rx_en  <= in_wake;
         if (woken_ff || wake_pulse) begin
            bus_receive_out <= 1'b0;
         end else if (in_normal || in_rxonly) begin
            bus_receive_out <= ~dom_s;
         end else begin
            bus_receive_out <= 1'b1;
         end
      end
   end
endmodule // cwf_chan

// File: core/cwf_regs.vh
// Constants for the CAN transceiver wake and fault control block
`ifndef CWF_REGS_VH
`define CWF_REGS_VH

// Transceiver mode codes (software mode field)
`define CWF_MODE_OFF       2'b00
`define CWF_MODE_WAKE      2'b01
`define CWF_MODE_RXONLY    2'b10
`define CWF_MODE_NORMAL    2'b11
`define CWF_MODE_RESET     2'b00

// Chip state codes (input from chip mode control)
`define CWF_CHIP_INIT      3'h0
`define CWF_CHIP_NORMAL    3'h1
`define CWF_CHIP_STOP      3'h2
`define CWF_CHIP_SLEEP     3'h3
`define CWF_CHIP_RESTART   3'h4
`define CWF_CHIP_FAILSAFE  3'h5

// Wake request codes to chip mode control
`define CWF_REQ_NONE       2'b00
`define CWF_REQ_RESTART    2'b01

// Timing in ns, and the clock period in ns
`define CWF_CLK_PERIOD_NS  10
`define CWF_WAKE1_NS       1000
`define CWF_WAKE2_NS       1000000
`define CWF_TXD_TO_NS      2000000
`define CWF_BUS_TO_NS      2000000

// Cycle counts: least times round up, longest time rounds down
`define CWF_WAKE1_CYC  ((`CWF_WAKE1_NS + `CWF_CLK_PERIOD_NS - 1) / `CWF_CLK_PERIOD_NS)
`define CWF_WAKE2_CYC  (`CWF_WAKE2_NS / `CWF_CLK_PERIOD_NS)
`define CWF_TXD_TO_CYC ((`CWF_TXD_TO_NS + `CWF_CLK_PERIOD_NS - 1) / `CWF_CLK_PERIOD_NS)
`define CWF_BUS_TO_CYC ((`CWF_BUS_TO_NS + `CWF_CLK_PERIOD_NS - 1) / `CWF_CLK_PERIOD_NS)

`endif

// File: core/cwf_sync.v
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module cwf_sync #(
   parameter WIDTH = 4
) (
   input  wire             core_clk,  // Core clock
   input  wire             rst_n,     // Synchronous reset, active low
   input  wire [WIDTH-1:0] async_in,  // Asynchronous levels
   output wire [WIDTH-1:0] sync_out   // Synchronised levels
);
   reg [WIDTH-1:0] stage1_ff;
   reg [WIDTH-1:0] stage2_ff;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         stage1_ff <= {WIDTH{1'b0}};
         stage2_ff <= {WIDTH{1'b0}};
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;
endmodule // cwf_sync

// File: testbench/cwf_chan_checker.sv
// Concurrent assertions on the ports of the CAN channel wake and fault block
`timescale 1ns/1ps
`include "cwf_regs.vh"
module cwf_chan_checker #(
   parameter TXD_TO_CYC = `CWF_TXD_TO_CYC
) (
   input wire       core_clk,
   input wire       rst_n,
   input wire [1:0] mode_wr_data,
   input wire       mode_wr_en,
   input wire [1:0] mode_rd,
   input wire [2:0] chip_state,
   input wire       bus_transmit_in,
   input wire       bus_dominant_in,
   input wire       xcvr_supply_ok_in,
   input wire       dog_enable_on_bus_wake,
   input wire       dog_enabled,
   input wire       wake_flag_clr,
   input wire       fail_flag_clr,
   input wire       uv_flag_clr,
   input wire       bus_receive_out,
   input wire       irq_out_n,
   input wire       chan_bus_wake_flag,
   input wire       chan_fail_flag,
   input wire       xcvr_supply_low_flag,
   input wire [1:0] chip_wake_req,
   input wire       dog_enable_set,
   input wire       main_supply_ramp,
   input wire       drv_en,
   input wire       bus_bias_en,
   input wire       wake_rx_en
);
   reg  [19:0] tx_low_ff;
   wire        tx_stuck = !bus_transmit_in && mode_rd == `CWF_MODE_NORMAL
                          && chip_state == `CWF_CHIP_NORMAL;
   wire [19:0] nxt_tx_low = tx_stuck ? tx_low_ff + {19'h0, tx_low_ff != 20'hfffff} : 20'h0;
   always @(posedge core_clk) begin
      if (!rst_n) tx_low_ff <= 20'h0;
      else tx_low_ff <= nxt_tx_low;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence wake_ind;
      !irq_out_n || chip_wake_req != `CWF_REQ_NONE;
   endsequence
   sequence off_settled;
      (mode_rd == `CWF_MODE_OFF && chip_state != `CWF_CHIP_FAILSAFE) [*3];
   endsequence
   sequence uv_settled;
      (!xcvr_supply_ok_in && mode_rd == `CWF_MODE_NORMAL && chip_state == `CWF_CHIP_NORMAL) [*5];
   endsequence
   chk_rx_on_wake: assert property (wake_ind |-> !bus_receive_out && chan_bus_wake_flag)
      else $error("wake indication without receive low and status set");
   chk_irq_state: assert property (!irq_out_n |-> $past(chip_state) == `CWF_CHIP_NORMAL
      || $past(chip_state) == `CWF_CHIP_STOP) else $error("interrupt in wrong chip state");
   chk_irq_pulse: assert property (!irq_out_n |=> irq_out_n)
      else $error("interrupt longer than one cycle");
   chk_req_state: assert property (chip_wake_req != `CWF_REQ_NONE |-> irq_out_n
      && $past(chip_state) >= `CWF_CHIP_SLEEP) else $error("restart request in wrong state");
   chk_ramp_cause: assert property (main_supply_ramp |-> chip_wake_req == `CWF_REQ_RESTART
      && ($past(chip_state) == `CWF_CHIP_SLEEP || $past(chip_state) == `CWF_CHIP_FAILSAFE))
      else $error("supply ramp without sleep or fail-safe wake");
   chk_dog_cause: assert property (dog_enable_set |-> !irq_out_n && $past(chip_state) ==
      `CWF_CHIP_STOP && $past(dog_enable_on_bus_wake) && !$past(dog_enabled))
      else $error("watchdog enable without stop-state wake");
   chk_mode_write: assert property (mode_wr_en |=> mode_rd == $past(mode_wr_data))
      else $error("mode field did not take the write");
   chk_mode_kept: assert property (!mode_wr_en |=> $stable(mode_rd))
      else $error("mode field changed without a write");
   chk_off_quiet: assert property (off_settled |-> !drv_en && !bus_bias_en)
      else $error("driver or bias active in off mode");
   chk_rxonly_drv: assert property ((mode_rd == `CWF_MODE_RXONLY && chip_state ==
      `CWF_CHIP_NORMAL) [*3] |-> !drv_en && bus_bias_en) else $error("receive-only driver state");
   chk_uv_drv: assert property (uv_settled |-> !drv_en && xcvr_supply_low_flag)
      else $error("undervoltage not acted on");
   chk_txd_to: assert property (tx_low_ff > TXD_TO_CYC + 6 |-> !drv_en)
      else $error("driver still on after transmit timeout");
endmodule // cwf_chan_checker

bind cwf_chan cwf_chan_checker #(.TXD_TO_CYC(TXD_TO_CYC)) u_chk (.core_clk, .rst_n,
   .mode_wr_data, .mode_wr_en, .mode_rd, .chip_state, .bus_transmit_in, .bus_dominant_in,
   .xcvr_supply_ok_in, .dog_enable_on_bus_wake, .dog_enabled, .wake_flag_clr, .fail_flag_clr,
   .uv_flag_clr, .bus_receive_out, .irq_out_n, .chan_bus_wake_flag, .chan_fail_flag,
   .xcvr_supply_low_flag, .chip_wake_req, .dog_enable_set, .main_supply_ramp, .drv_en,
   .bus_bias_en, .wake_rx_en);

// File: testbench/cwf_bus_model.sv
// Far side: remote bus nodes and the controller transmit pin
`timescale 1ns/1ps
module cwf_bus_model (
   input  wire core_clk,        // Core clock
   input  wire drv_en,          // Our bus driver enable
   output wire bus_dominant_in, // Bus level at the receiver
   output wire bus_transmit_in  // Controller transmit pin
);
   reg remote_dom_ff = 1'b0;
   reg tx_ff         = 1'b1;
   // Terminated bus is recessive unless a node drives it
   assign bus_dominant_in = remote_dom_ff | (drv_en & ~tx_ff);
   assign bus_transmit_in = tx_ff;
   task dom(input integer n);
      begin
         @(posedge core_clk) remote_dom_ff <= 1'b1;
         repeat (n) @(posedge core_clk);
         remote_dom_ff <= 1'b0;
      end
   endtask
   task wake(input integer d1, input integer g, input integer d2);
      begin
         dom(d1);
         repeat (g) @(posedge core_clk);
         dom(d2);
      end
   endtask
   task tx_set(input v);
      @(posedge core_clk) tx_ff <= v;
   endtask
endmodule // cwf_bus_model

// File: testbench/tb.sv
// Self-checking testbench for the CAN channel wake and fault block
`timescale 1ns/1ps
`include "cwf_regs.vh"
module tb;
   reg        core_clk, rst_n, mode_wr_en, dog_enable_on_bus_wake, dog_enabled;
   reg        xcvr_supply_ok_in, wake_flag_clr, fail_flag_clr, uv_flag_clr;
   reg  [1:0] mode_wr_data;
   reg  [2:0] chip_state, st;
   wire [1:0] mode_rd, chip_wake_req;
   wire       bus_transmit_in, bus_dominant_in, bus_receive_out, irq_out_n, drv_en;
   wire       chan_bus_wake_flag, chan_fail_flag, xcvr_supply_low_flag, dog_enable_set;
   wire       main_supply_ramp, bus_bias_en, wake_rx_en;
   integer    bad_count = 0, compares = 0, seed = 43, i;
   reg  [3:0] notes[$];
   reg  [3:0] note;
   cwf_chan #(.WAKE1_CYC(4), .WAKE2_CYC(20), .TXD_TO_CYC(30), .BUS_TO_CYC(30)) dut (.core_clk,
      .rst_n, .mode_wr_data, .mode_wr_en, .mode_rd, .chip_state, .bus_transmit_in,
      .bus_dominant_in, .xcvr_supply_ok_in, .dog_enable_on_bus_wake, .dog_enabled,
      .wake_flag_clr, .fail_flag_clr, .uv_flag_clr, .bus_receive_out, .irq_out_n,
      .chan_bus_wake_flag, .chan_fail_flag, .xcvr_supply_low_flag, .chip_wake_req,
      .dog_enable_set, .main_supply_ramp, .drv_en, .bus_bias_en, .wake_rx_en);
   cwf_bus_model u_bus (.core_clk, .drv_en, .bus_dominant_in, .bus_transmit_in);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task check(input [7:0] seen, input [7:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("compares %0d mismatches %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   // Returns just after the edge so that registered outputs have settled
   task cyc(input integer n);
      begin
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask
   task set_mode(input [1:0] m);
      begin
         @(posedge core_clk);
         mode_wr_data <= m;
         mode_wr_en   <= 1'b1;
         @(posedge core_clk);
         mode_wr_en   <= 1'b0;
      end
   endtask
   task go_state(input [2:0] s);
      @(posedge core_clk) chip_state <= s;
   endtask
   task rnd_wake;
      u_bus.wake(6 + {$random(seed)} % 4, 1 + {$random(seed)} % 10, 6 + {$random(seed)} % 4);
   endtask
   task expect_wake(input [3:0] n);
      begin
         notes.push_back(n);
         rnd_wake;
         cyc(6);
      end
   endtask
   // Each wake indication must match the oldest expected note
   always @(posedge core_clk) begin
      #1;
      if (rst_n === 1'b1 && (irq_out_n === 1'b0 || chip_wake_req !== `CWF_REQ_NONE)) begin
         if (notes.size() == 0) check(8'h1, 8'h0);
         else begin
            note = notes.pop_front();
            check({!irq_out_n, chip_wake_req == `CWF_REQ_RESTART, main_supply_ramp,
                   dog_enable_set}, note);
            check({bus_receive_out, chan_bus_wake_flag}, 8'h1);
         end
      end
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      test_done;
   end
   initial begin
      rst_n = 1'b0;
      mode_wr_en = 1'b0;
      mode_wr_data = `CWF_MODE_OFF;
      chip_state = `CWF_CHIP_NORMAL;
      xcvr_supply_ok_in = 1'b1;
      dog_enable_on_bus_wake = 1'b1;
      dog_enabled = 1'b0;
      wake_flag_clr = 1'b0;
      fail_flag_clr = 1'b0;
      uv_flag_clr = 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      cyc(3);
      check({mode_rd, bus_receive_out, irq_out_n, chan_bus_wake_flag, chan_fail_flag, drv_en,
             bus_bias_en}, 8'h30);
      rnd_wake;
      cyc(6);
      set_mode(`CWF_MODE_WAKE);
      cyc(3);
      u_bus.wake(3, 4, 3);
      cyc(30);
      u_bus.wake(8, 25, 8);
      cyc(30);
      $display("test reset and pattern done");
      for (i = 1; i <= 5; i = i + 1) begin
         st = i;
         @(posedge core_clk) {dog_enable_on_bus_wake, dog_enabled} <= 2'($random(seed));
         go_state(st);
         set_mode(`CWF_MODE_OFF);
         if (st != `CWF_CHIP_FAILSAFE) set_mode(`CWF_MODE_WAKE);
         cyc(3);
         check(wake_rx_en, 8'h1);
         expect_wake({st <= `CWF_CHIP_STOP, st >= `CWF_CHIP_SLEEP, st == `CWF_CHIP_SLEEP ||
                      st == `CWF_CHIP_FAILSAFE,
                      st == `CWF_CHIP_STOP && dog_enable_on_bus_wake && !dog_enabled});
         rnd_wake;
         cyc(6);
         check(bus_receive_out, 8'h0);
         if (st != `CWF_CHIP_FAILSAFE) check(mode_rd, `CWF_MODE_WAKE);
      end
      go_state(`CWF_CHIP_NORMAL);
      set_mode(`CWF_MODE_NORMAL);
      cyc(4);
      check({bus_receive_out, drv_en}, 8'h3);
      set_mode(`CWF_MODE_WAKE);
      cyc(3);
      expect_wake(4'b1000);
      @(posedge core_clk) {dog_enable_on_bus_wake, dog_enabled} <= 2'b10;
      go_state(`CWF_CHIP_STOP);
      cyc(3);
      expect_wake(4'b1001);
      $display("test wake and rearm done");
      go_state(`CWF_CHIP_NORMAL);
      set_mode(`CWF_MODE_NORMAL);
      cyc(4);
      u_bus.tx_set(1'b0);
      cyc(40);
      check({chan_fail_flag, drv_en, mode_rd}, {6'h02, `CWF_MODE_NORMAL});
      u_bus.tx_set(1'b1);
      cyc(5);
      check({drv_en, mode_rd}, {6'h1, `CWF_MODE_NORMAL});
      set_mode(`CWF_MODE_OFF);
      @(posedge core_clk) {fail_flag_clr, wake_flag_clr} <= 2'b11;
      @(posedge core_clk) {fail_flag_clr, wake_flag_clr} <= 2'b00;
      cyc(2);
      check({chan_fail_flag, chan_bus_wake_flag}, 8'h0);
      u_bus.dom(40);
      cyc(3);
      check({chan_fail_flag, mode_rd}, {6'h1, `CWF_MODE_OFF});
      $display("test timeouts done");
      set_mode(`CWF_MODE_NORMAL);
      cyc(4);
      @(posedge core_clk) xcvr_supply_ok_in <= 1'b0;
      cyc(8);
      check({xcvr_supply_low_flag, drv_en}, 8'h2);
      @(posedge core_clk) xcvr_supply_ok_in <= 1'b1;
      cyc(5);
      check({drv_en, mode_rd}, {6'h1, `CWF_MODE_NORMAL});
      @(posedge core_clk) uv_flag_clr <= 1'b1;
      @(posedge core_clk) uv_flag_clr <= 1'b0;
      cyc(2);
      check(xcvr_supply_low_flag, 8'h0);
      set_mode(`CWF_MODE_RXONLY);
      cyc(4);
      check({drv_en, bus_bias_en}, 8'h1);
      check(notes.size(), 8'h0);
      $display("test supply and receive-only done");
      test_done;
   end
endmodule // tb
